/* hw/fvg_pkg.sv */
// Constants, register map and command layout of the FPU graphics support block.
// Assumes a single core clock domain and software access over AHB-Lite.
// Summary of operation
// - Dot product of two four-element vectors at base 0/4/8/12; squares when equal.
// - Dot product always sets inexact cause and flag; traps if inexact enabled.
// - Transform always sets inexact cause and flag; traps if inexact enabled.
// - Transform multiplies background sixteen-element matrix by vector at base 0/4/8/12.
// - Transform traps whenever invalid-operation enable is set.
// - Products may drop small partial terms within the stated error bound.
// - Bank toggle inverts the bank select bit within one cycle.
// - Status/control register load takes four cycles.
// - With transfer-size set, moves carry two 32-bit words together.
// - Paired moves use even pairs 0..14, either bank; memory via register 0..15.
// - Size toggle inverts the transfer-size bit.
// - Bank select bit 21 picks which physical bank is foreground.
// - Transfer-size bit 20: 0 gives 32-bit moves, 1 gives pair moves.
// - Graphics operations are undefined in double-precision mode; only dot product and transform are refused, toggles and moves still run.
// - When a trap is taken, destination registers stay unchanged.
package fvg_pkg;

  // Register byte offsets
  localparam logic [9:0] FVG_OFS_STATUS_CTRL = 10'h000;
  localparam logic [9:0] FVG_OFS_COMMAND     = 10'h004;
  localparam logic [9:0] FVG_OFS_STATE       = 10'h008;
  localparam logic [9:0] FVG_OFS_MOVE_LO     = 10'h00c;
  localparam logic [9:0] FVG_OFS_MOVE_HI     = 10'h010;
  localparam logic [9:0] FVG_OFS_REGFILE     = 10'h100;

  // Status/control field positions and reset value
  localparam int FVG_BIT_BANK_SWAP   = 21;
  localparam int FVG_BIT_PAIR_SIZE   = 20;
  localparam int FVG_BIT_WIDE_FLOAT  = 19;
  localparam int FVG_BIT_CAUSE_V     = 16;
  localparam int FVG_BIT_CAUSE_I     = 12;
  localparam int FVG_BIT_ENABLE_V    = 11;
  localparam int FVG_BIT_ENABLE_I    = 7;
  localparam int FVG_BIT_FLAG_V      = 6;
  localparam int FVG_BIT_FLAG_I      = 2;
  localparam int FVG_CAUSE_LO        = 12;
  localparam int FVG_CAUSE_HI        = 17;
  localparam logic [31:0] FVG_STATUS_CTRL_RESET = 32'h0004_0001;
  localparam logic [31:0] FVG_STATUS_CTRL_MASK  = 32'h003f_ffff;

  // System register load occupancy: 4 cycles at 125 MHz
  localparam int FVG_CLK_NS        = 8;
  localparam int FVG_LOAD_NS       = 32;
  localparam int FVG_LOAD_CYCLES   = (FVG_LOAD_NS + FVG_CLK_NS - 1) / FVG_CLK_NS;
  localparam logic [2:0] FVG_LOAD_WAIT = 3'(FVG_LOAD_CYCLES - 1);

  // Operation codes
  localparam logic [2:0] FVG_OP_NONE     = 3'h0;
  localparam logic [2:0] FVG_OP_DOT      = 3'h1;
  localparam logic [2:0] FVG_OP_XFORM    = 3'h2;
  localparam logic [2:0] FVG_OP_BANK_TOG = 3'h3;
  localparam logic [2:0] FVG_OP_SIZE_TOG = 3'h4;
  localparam logic [2:0] FVG_OP_MOVE     = 3'h5;

  typedef struct packed {
    logic [7:0] spare3;
    logic [3:0] genReg;
    logic [1:0] spare2;
    logic       toMem;
    logic       dstBg;
    logic [3:0] dst;
    logic [2:0] spare1;
    logic       srcBg;
    logic [3:0] src;
    logic       spare0;
    logic [2:0] op;
  } fvg_cmd_s;

  typedef enum logic [1:0] {FVG_IDLE, FVG_DOT, FVG_XFORM} fvg_state_e;

endpackage : fvg_pkg

/* hw/fvg_graphics.sv */
// FPU graphics support: dot product, matrix transform, bank/size toggles, moves.
// Assumes one AHB-Lite master and the core clock and reset.
`timescale 1ns/1ns
`default_nettype none
module fvg_graphics (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             fpuTrap
);
  import fvg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Float helpers, truncating: low partial products are dropped
  function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] m;
    logic [9:0]  e;
    logic [22:0] f;
    logic        s;
    s = a[31] ^ b[31];
    m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = 10'(a[30:23]) + 10'(b[30:23]) - 10'd127;
    if (m[47]) begin
      f = m[46:24];
      e = e + 10'd1;
    end else begin
      f = m[45:23];
    end
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] || e == 10'd0) fmul = {s, 31'h0};
    else if (e >= 10'd255) fmul = {s, 8'hff, 23'h0};
    else fmul = {s, e[7:0], f};
  endfunction : fmul

  function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
    logic [31:0] a;
    logic [31:0] b;
    logic [26:0] ma;
    logic [26:0] mb;
    logic [26:0] sm;
    logic [8:0]  e;
    logic [7:0]  d;
    logic        done;
    if (x[30:0] >= y[30:0]) begin
      a = x;
      b = y;
    end else begin
      a = y;
      b = x;
    end
    d = a[30:23] - b[30:23];
    ma = {1'b0, 1'b1, a[22:0], 2'b00};
    mb = (b[30:23] == 8'h00 || d > 8'd26) ? 27'h0 : ({1'b0, 1'b1, b[22:0], 2'b00} >> d);
    sm = (a[31] == b[31]) ? ma + mb : ma - mb;
    e = {1'b0, a[30:23]};
    done = 1'b0;
    if (sm[26]) begin
      sm = sm >> 1;
      e = e + 9'd1;
    end
    for (int i = 0; i < 26; i++) begin
      if (!done && !sm[25] && sm != 27'h0 && e > 9'd1) begin
        sm = sm << 1;
        e = e - 9'd1;
      end else begin
        done = 1'b1;
      end
    end
    if (a[30:23] == 8'h00 || sm == 27'h0 || !sm[25]) fadd = (a[30:23] == 8'h00) ? b : 32'h0;
    else if (e >= 9'd255) fadd = {a[31], 8'hff, 23'h0};
    else fadd = {a[31], e[7:0], sm[24:2]};
  endfunction : fadd

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] fileReg [0:31];
  logic [31:0] statusCtrl_reg;
  logic [31:0] moveLo_reg;
  logic [31:0] moveHi_reg;
  logic [3:0]  moveGen_reg;
  logic        undefSeen_reg;
  logic        trapSeen_reg;
  fvg_state_e  state_reg;
  fvg_cmd_s    cmd_reg;
  logic [1:0]  row_reg;
  logic [1:0]  col_reg;
  logic [31:0] acc_reg;
  logic [31:0] res_reg [0:3];

  // AHB data-phase capture
  logic       dpValid_reg;
  logic       dpWrite_reg;
  logic [9:0] dpAddr_reg;
  logic [2:0] wait_reg;

  logic     addrPhase;
  logic     wrDone;
  logic     bankSel;
  fvg_cmd_s newCmd;
  logic     cmdWrite;
  logic     wideMode;

  assign addrPhase = hsel && htrans[1] && hready;
  assign hreadyout = (wait_reg == 3'h0);
  assign hresp     = 1'b0;
  assign wrDone    = dpValid_reg && dpWrite_reg && hreadyout;
  assign bankSel   = statusCtrl_reg[FVG_BIT_BANK_SWAP];
  assign wideMode  = statusCtrl_reg[FVG_BIT_WIDE_FLOAT];
  assign newCmd    = fvg_cmd_s'(hwdata);
  assign cmdWrite  = wrDone && dpAddr_reg == FVG_OFS_COMMAND;

  // Foreground index to physical slot; background is the other bank
  function automatic logic [4:0] fg(input logic [3:0] idx, input logic bg);
    fg = {bankSel ^ bg, idx};
  endfunction : fg

  // Register file window: 32 word slots above the file offset, nothing beyond
  function automatic logic inFile(input logic [9:0] a);
    inFile = a[9:7] == FVG_OFS_REGFILE[9:7];
  endfunction : inFile

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dpValid_reg <= 1'b0;
      dpWrite_reg <= 1'b0;
      dpAddr_reg  <= 10'h0;
      wait_reg    <= 3'h0;
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
    end else begin
      dpValid_reg <= addrPhase;
      dpWrite_reg <= hwrite;
      dpAddr_reg  <= haddr[9:0];
      if (addrPhase && hwrite && haddr[9:0] == FVG_OFS_STATUS_CTRL)
        wait_reg <= FVG_LOAD_WAIT;
    end
  end

  // Read data captured at the address phase, stands through the data phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0;
    end else if (addrPhase && !hwrite) begin
      if (inFile(haddr[9:0])) hrdata <= fileReg[haddr[6:2]];
      else begin
        case (haddr[9:0])
          FVG_OFS_STATUS_CTRL: hrdata <= statusCtrl_reg;
          FVG_OFS_COMMAND:     hrdata <= 32'(cmd_reg);
          FVG_OFS_STATE:       hrdata <= {24'h0, moveGen_reg, trapSeen_reg, undefSeen_reg,
                                          state_reg != FVG_IDLE, 1'b0};
          FVG_OFS_MOVE_LO:     hrdata <= moveLo_reg;
          FVG_OFS_MOVE_HI:     hrdata <= moveHi_reg;
          default:             hrdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance
  logic dotGo;
  logic xformGo;
  logic moveGo;
  logic idle;
  logic pairOdd;

  assign idle    = state_reg == FVG_IDLE;
  assign pairOdd = statusCtrl_reg[FVG_BIT_PAIR_SIZE] && (newCmd.src[0] || newCmd.dst[0]);
  assign dotGo   = cmdWrite && idle && !wideMode && newCmd.op == FVG_OP_DOT
                   && newCmd.src[1:0] == 2'b00 && newCmd.dst[1:0] == 2'b00;
  assign xformGo = cmdWrite && idle && !wideMode && newCmd.op == FVG_OP_XFORM
                   && newCmd.dst[1:0] == 2'b00;
  assign moveGo  = cmdWrite && idle && newCmd.op == FVG_OP_MOVE && !pairOdd;

  // Refused commands change nothing but this marker and the latched command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      undefSeen_reg <= 1'b0;
    end else if (cmdWrite && idle) begin
      undefSeen_reg <= (wideMode && newCmd.op inside {FVG_OP_DOT, FVG_OP_XFORM})
                       || (newCmd.op == FVG_OP_MOVE && pairOdd)
                       || (newCmd.op == FVG_OP_DOT && (newCmd.src[1:0] != 2'b00
                           || newCmd.dst[1:0] != 2'b00))
                       || (newCmd.op == FVG_OP_XFORM && newCmd.dst[1:0] != 2'b00)
                       || newCmd.op > FVG_OP_MOVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one product per cycle, four per element
  logic [31:0] prodA;
  logic [31:0] prodB;
  logic [31:0] prod;
  logic [31:0] sum;
  logic        lastStep;
  logic        opEnd;
  logic        trapNow;

  always_comb begin
    if (state_reg == FVG_DOT) begin
      prodA = fileReg[fg({cmd_reg.src[3:2], col_reg}, 1'b0)];
      prodB = fileReg[fg({cmd_reg.dst[3:2], col_reg}, 1'b0)];
    end else begin
      prodA = fileReg[fg({col_reg, row_reg}, 1'b1)];
      prodB = fileReg[fg({cmd_reg.dst[3:2], col_reg}, 1'b0)];
    end
  end

  assign prod     = fmul(prodA, prodB);
  assign sum      = (col_reg == 2'h0) ? prod : fadd(acc_reg, prod);
  assign lastStep = col_reg == 2'h3;
  assign opEnd    = lastStep && (state_reg == FVG_DOT || row_reg == 2'h3);
  assign trapNow  = opEnd && (statusCtrl_reg[FVG_BIT_ENABLE_I]
                    || (state_reg == FVG_XFORM && statusCtrl_reg[FVG_BIT_ENABLE_V]));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= FVG_IDLE;
      cmd_reg   <= '0;
      row_reg   <= 2'h0;
      col_reg   <= 2'h0;
      acc_reg   <= 32'h0;
    end else begin
      case (state_reg)
        FVG_IDLE: begin
          if (cmdWrite && idle) cmd_reg <= newCmd;
          row_reg <= 2'h0;
          col_reg <= 2'h0;
          if (dotGo) state_reg <= FVG_DOT;
          else if (xformGo) state_reg <= FVG_XFORM;
        end
        FVG_DOT, FVG_XFORM: begin
          acc_reg <= sum;
          col_reg <= col_reg + 2'h1;
          if (lastStep) row_reg <= row_reg + 2'h1;
          if (opEnd) state_reg <= FVG_IDLE;
        end
        default: state_reg <= FVG_IDLE;
      endcase
    end
  end

  // Rows held back so a trapped transform leaves the destination intact
  always_ff @(posedge clock) begin
    if (state_reg == FVG_XFORM && lastStep) res_reg[row_reg] <= sum;
  end

  always_ff @(posedge clock or negedge nrst) begin
    // Registered pulse, one cycle after the last product
    if (!nrst) fpuTrap <= 1'b0;
    else fpuTrap <= trapNow;
  end

  always_ff @(posedge clock or negedge nrst) begin
    // Trap set wins over the clear of a new operation
    if (!nrst) trapSeen_reg <= 1'b0;
    else if (trapNow) trapSeen_reg <= 1'b1;
    else if (dotGo || xformGo) trapSeen_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status/control register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      statusCtrl_reg <= FVG_STATUS_CTRL_RESET;
    end else begin
      if (wrDone && dpAddr_reg == FVG_OFS_STATUS_CTRL)
        statusCtrl_reg <= hwdata & FVG_STATUS_CTRL_MASK;
      // Later assignments: hardware flag set wins over a coincident software write
      if (dotGo || xformGo)
        statusCtrl_reg[FVG_CAUSE_HI:FVG_CAUSE_LO] <= 6'h00;
      if (opEnd) begin
        statusCtrl_reg[FVG_BIT_CAUSE_I] <= 1'b1;
        statusCtrl_reg[FVG_BIT_FLAG_I]  <= 1'b1;
        if (state_reg == FVG_XFORM && statusCtrl_reg[FVG_BIT_ENABLE_V]) begin
          statusCtrl_reg[FVG_BIT_CAUSE_V] <= 1'b1;
          statusCtrl_reg[FVG_BIT_FLAG_V]  <= 1'b1;
        end
      end
      if (cmdWrite && idle && newCmd.op == FVG_OP_BANK_TOG)
        statusCtrl_reg[FVG_BIT_BANK_SWAP] <= ~bankSel;
      if (cmdWrite && idle && newCmd.op == FVG_OP_SIZE_TOG)
        statusCtrl_reg[FVG_BIT_PAIR_SIZE] <= ~statusCtrl_reg[FVG_BIT_PAIR_SIZE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file: software, moves and results
  logic        pairMode;
  logic [4:0]  srcSlot;
  logic [4:0]  dstSlot;

  assign pairMode = statusCtrl_reg[FVG_BIT_PAIR_SIZE];
  assign srcSlot  = fg(newCmd.src, newCmd.srcBg);
  assign dstSlot  = fg(newCmd.dst, newCmd.dstBg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) fileReg[i] <= 32'h0;
    end else begin
      if (wrDone && inFile(dpAddr_reg))
        fileReg[dpAddr_reg[6:2]] <= hwdata;
      if (moveGo && !newCmd.toMem) begin
        fileReg[dstSlot] <= fileReg[srcSlot];
        if (pairMode) fileReg[dstSlot | 5'h01] <= fileReg[srcSlot | 5'h01];
      end
      if (opEnd && !trapNow) begin
        if (state_reg == FVG_DOT) begin
          fileReg[fg({cmd_reg.dst[3:2], 2'h3}, 1'b0)] <= sum;
        end else begin
          for (int k = 0; k < 3; k++)
            fileReg[fg({cmd_reg.dst[3:2], 2'(k)}, 1'b0)] <= res_reg[k];
          fileReg[fg({cmd_reg.dst[3:2], 2'h3}, 1'b0)] <= sum;
        end
      end
    end
  end

  // Moves to memory land in the transfer words, tagged with the address register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      moveLo_reg  <= 32'h0;
      moveHi_reg  <= 32'h0;
      moveGen_reg <= 4'h0;
    end else if (moveGo && newCmd.toMem) begin
      moveLo_reg  <= fileReg[srcSlot];
      moveHi_reg  <= pairMode ? fileReg[srcSlot | 5'h01] : 32'h0;
      moveGen_reg <= newCmd.genReg;
    end
  end

endmodule : fvg_graphics
`default_nettype wire

/* tb/fvg_graphics_properties.sv */
// Concurrent checks on bus timing, load wait and trap pulse of the graphics block.
// Sees only the top module's ports; bound to every fvg_graphics instance.
`timescale 1ns/1ns
`default_nettype none
module fvg_graphics_properties (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        fpuTrap
);
  import fvg_pkg::*;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  logic       taken;
  logic       statWr;
  logic       cmdPend_reg;
  logic [5:0] sinceCmd_reg;
  logic [2:0] statCnt_reg;
  assign taken  = hsel && htrans[1] && hready;
  assign statWr = taken && hwrite && (haddr[9:0] == FVG_OFS_STATUS_CTRL);
  //////////////////////////////////////////////////////////////////////////////
  // Cycles since the last command write completed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmdPend_reg  <= 1'b0;
      sinceCmd_reg <= 6'h3f;
    end else begin
      cmdPend_reg <= taken ? (hwrite && haddr[9:0] == FVG_OFS_COMMAND) : cmdPend_reg && !hreadyout;
      if (cmdPend_reg && hreadyout) begin
        sinceCmd_reg <= 6'h00;
      end else if (sinceCmd_reg != 6'h3f) begin
        sinceCmd_reg <= sinceCmd_reg + 6'h01;
      end
    end
  end
  // Wait cycles left of a status/control load
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      statCnt_reg <= 3'h0;
    end else if (statWr) begin
      statCnt_reg <= 3'h3;
    end else if (statCnt_reg != 3'h0) begin
      statCnt_reg <= statCnt_reg - 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_LOAD_WAIT: assert property (statWr |=> !hreadyout [*3] ##1 hreadyout)
    else $error("status load wait not four data cycles");
  AST_LOW_ONLY_LOAD: assert property (!hreadyout |-> statCnt_reg != 3'h0)
    else $error("wait state outside a status load");
  AST_READY_OTHER: assert property (taken && !statWr |=> hreadyout)
    else $error("wait state on a plain transfer");
  AST_RDATA_HOLD: assert property (!(taken && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_RESERVED_ZERO: assert property (
    taken && !hwrite && haddr[9:0] == FVG_OFS_STATUS_CTRL |=> hrdata[31:22] == 10'h000)
    else $error("reserved status bits read nonzero");
  AST_TRAP_PULSE: assert property (fpuTrap |=> !fpuTrap)
    else $error("trap longer than one cycle");
  AST_TRAP_AFTER_OP: assert property (fpuTrap |-> sinceCmd_reg inside {[3:24]})
    else $error("trap not tied to a recent operation");
endmodule : fvg_graphics_properties
bind fvg_graphics fvg_graphics_properties i_props (.clock(clock), .nrst(nrst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fpuTrap(fpuTrap));
`default_nettype wire

/* tb/fvg_core_model.sv */
// Core-side model: single-word AHB-Lite master issuing the block's transfers.
// Assumes hready is the block's hreadyout; tasks are entered just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module fvg_core_model (
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic [31:0] rdWord,
  output var  logic        rdToggle
);
  initial begin
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    rdWord   = 32'h0;
    rdToggle = 1'b0;
  end
  // One transfer; released lines show inverted data, never the stale value
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic note, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
    if (note) begin
      rdWord   <= hrdata;
      rdToggle <= ~rdToggle;
    end
  endtask : xfer
endmodule : fvg_core_model
`default_nettype wire

/* tb/fvg_graphics_tb.sv */
// Self-checking bench: toggles, dot products, transforms, pair moves, traps, refusals.
// Drives fvg_graphics through fvg_core_model; read results are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
module fvg_graphics_tb;
  import fvg_pkg::*;
  logic        clock;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        fpuTrap;
  logic [31:0] rdWord;
  logic        rdToggle;
  logic [31:0] st;
  logic [31:0] rng;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int          slot[32];
  int          e[4];
  int          m;
  int          n;
  int          g;
  int          sum;
  int          fail_count;
  int          n_checks;
  int          trapCount;
  fvg_graphics i_dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fpuTrap(fpuTrap));
  fvg_core_model i_core (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rdWord(rdWord), .rdToggle(rdToggle));
  initial clock = 1'b0;
  always #4 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  // Exact single-precision image of a small non-negative integer
  function automatic logic [31:0] f2b(int k);
    int p;
    if (k == 0) return 32'h0;
    p = $clog2(k + 1) - 1;
    return {1'b0, 8'(127 + p), 23'(k << (23 - p))};
  endfunction : f2b
  function automatic logic [31:0] ra(logic [9:0] o);
    return {22'h0, o};
  endfunction : ra
  function automatic logic [31:0] sa(int s);
    return ra(FVG_OFS_REGFILE) + 32'(4 * s);
  endfunction : sa
  function automatic logic [31:0] mkCmd(logic [2:0] op, int s, int d, logic mem, int gr);
    fvg_cmd_s c;
    c = '0;
    c.op = op;
    c.src = 4'(s);
    c.dst = 4'(d);
    c.toMem = mem;
    c.genReg = 4'(gr);
    return c;
  endfunction : mkCmd
  task automatic cmp(input logic [31:0] got, input logic [31:0] x);
    n_checks++;
    if (got !== x) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, x);
    end
  endtask : cmp
  task automatic chk(input logic [31:0] a, input logic [31:0] msk, input logic [31:0] x);
    logic [31:0] q;
    expQ.push_back(x & msk);
    mskQ.push_back(msk);
    i_core.xfer(a, 1'b0, 32'h0, 1'b1, q);
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_core.xfer(a, 1'b1, d, 1'b0, q);
  endtask : wr
  // Polls busy with a bounded count; a stuck busy counts as a mismatch
  task automatic runOp(input logic [31:0] c);
    logic [31:0] q;
    int          k;
    wr(ra(FVG_OFS_COMMAND), c);
    q = 32'h2;
    k = 0;
    while (q[1] !== 1'b0 && k < 50) begin
      i_core.xfer(ra(FVG_OFS_STATE), 1'b0, 32'h0, 1'b0, q);
      k++;
    end
    if (k >= 50) cmp(q, 32'h0);
  endtask : runOp
  task automatic fillVec(input int b, input int md);
    for (int i = 0; i < 4; i++) begin
      slot[b + i] = int'(rnd() % 32'(md));
      wr(sa(b + i), f2b(slot[b + i]));
    end
  endtask : fillVec
  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////////
  always @(rdToggle) begin
    if (expQ.size() > 0) begin
      cmp(rdWord & mskQ[0], expQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end
  always @(posedge clock) if (fpuTrap === 1'b1) trapCount++;
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("Watchdog expired at %0t", $time);
    print_verdict();
  end
  initial begin
    rng = 32'hf11c9b1a;
    nrst = 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    st = 32'h0004_0001;
    chk(ra(FVG_OFS_STATUS_CTRL), '1, st);
    for (int i = 0; i < 4; i++) begin
      wr(ra(FVG_OFS_COMMAND), mkCmd(i < 2 ? FVG_OP_BANK_TOG : FVG_OP_SIZE_TOG, 0, 0, 0, 0));
      st[i < 2 ? 21 : 20] ^= 1'b1;
      chk(ra(FVG_OFS_STATUS_CTRL), '1, st);
    end
    $display("test toggles done");
    for (int t = 0; t < 2; t++) begin
      m = 4 * int'(rnd() % 4);
      n = (t == 0) ? (m + 4) % 16 : m;
      fillVec(m, 8);
      if (t == 0) fillVec(n, 8);
      sum = 0;
      for (int i = 0; i < 4; i++) sum += slot[m + i] * slot[n + i];
      runOp(mkCmd(FVG_OP_DOT, m, n, 1'b0, 0));
      slot[n + 3] = sum;
      chk(sa(n + 3), '1, f2b(sum));
      st = (st & ~32'h3f000) | 32'h1004;
      chk(ra(FVG_OFS_STATUS_CTRL), '1, st);
    end
    $display("test dot product done");
    fillVec(16, 4);
    fillVec(20, 4);
    fillVec(24, 4);
    fillVec(28, 4);
    st = st & ~32'h3f07c;
    wr(ra(FVG_OFS_STATUS_CTRL), st);
    for (int j = 0; j < 16; j += 4) begin
      fillVec(j, 8);
      for (int r = 0; r < 4; r++) begin
        e[r] = 0;
        for (int c = 0; c < 4; c++) e[r] += slot[16 + 4 * c + r] * slot[j + c];
      end
      runOp(mkCmd(FVG_OP_XFORM, 0, j, 1'b0, 0));
      for (int r = 0; r < 4; r++) begin
        slot[j + r] = e[r];
        chk(sa(j + r), '1, f2b(e[r]));
      end
    end
    st = st | 32'h1004;
    chk(ra(FVG_OFS_STATUS_CTRL), '1, st);
    $display("test transform done");
    for (int k = 0; k < 3; k++) begin
      wr(ra(FVG_OFS_COMMAND), mkCmd(FVG_OP_SIZE_TOG, 0, 0, 1'b0, 0));
      if (k == 1) wr(ra(FVG_OFS_COMMAND), mkCmd(FVG_OP_SIZE_TOG, 0, 0, 1'b0, 0));
      m = (k == 0) ? 0 : (k == 1) ? 14 : 6;
      g = (k == 0) ? 0 : (k == 1) ? 15 : 5;
      runOp(mkCmd(FVG_OP_MOVE, m, 0, 1'b1, g));
      chk(ra(FVG_OFS_MOVE_LO), '1, f2b(slot[m]));
      chk(ra(FVG_OFS_MOVE_HI), '1, (k < 2) ? f2b(slot[m + 1]) : 32'h0);
      chk(ra(FVG_OFS_STATE), 32'hf0, 32'(g << 4));
      if (k == 1) begin
        runOp(mkCmd(FVG_OP_MOVE, 2, 8, 1'b0, 0));
        slot[8] = slot[2];
        slot[9] = slot[3];
        chk(sa(9), '1, f2b(slot[9]));
        runOp(mkCmd(FVG_OP_MOVE, 3, 0, 1'b1, 9));
        chk(ra(FVG_OFS_STATE), 32'hf4, 32'hf4);
      end
    end
    $display("test pair move done");
    st[7] = 1'b1;
    wr(ra(FVG_OFS_STATUS_CTRL), st);
    runOp(mkCmd(FVG_OP_DOT, 0, 4, 1'b0, 0));
    chk(sa(7), '1, f2b(slot[7]));
    chk(ra(FVG_OFS_STATE), 32'h8, 32'h8);
    cmp(32'(trapCount), 32'h1);
    st[7] = 1'b0;
    st[11] = 1'b1;
    wr(ra(FVG_OFS_STATUS_CTRL), st);
    runOp(mkCmd(FVG_OP_XFORM, 0, 12, 1'b0, 0));
    for (int r = 0; r < 4; r++) chk(sa(12 + r), '1, f2b(slot[12 + r]));
    st = (st & ~32'h3f000) | 32'h11044;
    chk(ra(FVG_OFS_STATUS_CTRL), '1, st);
    cmp(32'(trapCount), 32'h2);
    $display("test traps done");
    wr(ra(FVG_OFS_STATUS_CTRL), 32'hffc8_0000);
    chk(ra(FVG_OFS_STATUS_CTRL), '1, 32'h0008_0000);
    runOp(mkCmd(FVG_OP_DOT, 0, 4, 1'b0, 0));
    chk(ra(FVG_OFS_STATE), 32'h4, 32'h4);
    chk(sa(7), '1, f2b(slot[7]));
    cmp(32'(trapCount), 32'h2);
    wr(32'h0000_0180, rnd());
    chk(32'h0000_0180, '1, 32'h0);
    $display("test refusals done");
    print_verdict();
  end
endmodule : fvg_graphics_tb
`default_nettype wire
